// file: scd_pkg.sv
package scd_pkg;

    // Pin widths, bank count and busy timer width
    localparam int BANK_W = 3;
    localparam int ADDR_W = 14;
    localparam int NBANK  = 8;
    localparam int CNT_W  = 8;

    // Address bit positions
    localparam int AP_BIT   = 10;
    localparam int CHOP_BIT = 12;

    // Busy periods in clock cycles (nCK), plain defaults
    localparam logic [CNT_W-1:0] CYC_BL8  = 8'h04;
    localparam logic [CNT_W-1:0] CYC_BC4  = 8'h02;
    localparam logic [CNT_W-1:0] CYC_RP   = 8'h06;
    localparam logic [CNT_W-1:0] CYC_RFC  = 8'h40;
    localparam logic [CNT_W-1:0] CYC_MRD  = 8'h0c;
    localparam logic [CNT_W-1:0] CYC_ZQCL = 8'h80;
    localparam logic [CNT_W-1:0] CYC_ZQCS = 8'h20;
    localparam logic [CNT_W-1:0] CYC_XP   = 8'h04;
    localparam logic [CNT_W-1:0] CYC_XS   = 8'h50;
    localparam logic [CNT_W-1:0] CYC_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CYC_ONE  = 8'h01;

    // Operating states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ACTIVE, ST_READING, ST_WRITING, ST_PRECHARGING,
        ST_REFRESHING, ST_ACT_PD, ST_PRE_PD, ST_SELF_REF
    } scd_state_type;

    // Decoded commands
    typedef enum logic [2:0] {
        CMD_MODE_SET, CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVATE,
        CMD_WRITE, CMD_READ, CMD_CALIBRATE, CMD_NOP
    } scd_cmd_type;

endpackage

// file: scd_bank_table.sv
`timescale 1ns/100ps

module scd_bank_table
(
    // Clock and reset
    input  wire logic                      sys_clk_i,
    input  wire logic                      rstn_i,
    // Open and close requests
    input  wire logic                      open_i,
    input  wire logic                      close_i,
    input  wire logic                      close_all_i,
    input  wire logic [scd_pkg::BANK_W-1:0] bank_i,
    // Open banks
    output logic      [scd_pkg::NBANK-1:0]  open_mask_o
);

    ////////////////////////////////////////////////////////////////////////////
    // One flag per bank; close wins only over a stale open of another cycle
    genvar gi;
    generate
        for (gi = 0; gi < scd_pkg::NBANK; gi++)
        begin : g_bank
            always_ff @(posedge sys_clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                    open_mask_o[gi] <= 1'b0;
                else if (open_i && bank_i == scd_pkg::BANK_W'(gi))
                    open_mask_o[gi] <= 1'b1;
                else if (close_all_i || (close_i && bank_i == scd_pkg::BANK_W'(gi)))
                    open_mask_o[gi] <= 1'b0;
            end
        end
    endgenerate

endmodule // scd_bank_table

// file: scd_decode.sv
// Operation
// - Commands decode only from pins sampled at a rising clock edge.
// - Bank lines pick the target bank, or the mode register for mode set.
// - Unused upper bank, row and column bits are masked by configured density.
// - A started burst runs its full length only if no other command or clock-enable fall comes during it.
// - No internal refresh in any power-down state.
// - Decoding ignores termination input; termination off in self refresh.
// - Self refresh exit detected from clock-enable rising, not clock edges.
// - No-operation never disturbs an operation in progress.
// - Deselect behaves exactly as no-operation.
// - Clock-enable change judged from previous and current edge, prior state.
// - Fall during read, write, precharge: precharge or active power-down.
// - Fall while refreshing or idle enters precharge power-down.
// - Refresh with clock-enable fall enters self refresh only from idle.
// - Command and address ignored while held in power-down or self refresh.
// - Idle needs banks closed, no burst, clock-enable high, delays expired.
// - Strobe codes map to mode set, refresh, precharge, activate, etc.
// - Bit 10 requests auto precharge; bit 12 picks chop on the fly.
`timescale 1ns/100ps

module scd_decode
(
    // Clock and reset
    input  wire logic                         sys_clk_i,
    input  wire logic                         rstn_i,
    // Command pins
    input  wire logic                         cs_n_i,
    input  wire logic                         ras_n_i,
    input  wire logic                         cas_n_i,
    input  wire logic                         we_n_i,
    input  wire logic                         cke_i,
    input  wire logic                         odt_i,
    input  wire logic [scd_pkg::BANK_W-1:0]   ba_i,
    input  wire logic [scd_pkg::ADDR_W-1:0]   addr_i,
    // Configuration
    input  wire logic                         otf_bl_i,
    input  wire logic                         fixed_bc4_i,
    input  wire logic [3:0]                   row_bits_i,
    input  wire logic [3:0]                   col_bits_i,
    input  wire logic [1:0]                   bank_bits_i,
    // Command results
    output logic                              cmd_strobe_o,
    output scd_pkg::scd_cmd_type              cmd_o,
    output logic      [scd_pkg::BANK_W-1:0]   bank_o,
    output logic      [scd_pkg::ADDR_W-1:0]   row_o,
    output logic      [scd_pkg::ADDR_W-1:0]   col_o,
    output logic                              auto_pre_o,
    output logic                              chop_o,
    output logic                              long_cal_o,
    // Status
    output scd_pkg::scd_state_type            state_o,
    output logic      [scd_pkg::NBANK-1:0]    open_banks_o,
    output logic                              burst_active_o,
    output logic                              idle_o,
    output logic                              own_refresh_en_o,
    output logic                              odt_enable_o
);

    scd_pkg::scd_state_type             state;
    scd_pkg::scd_cmd_type               cmd;
    logic [scd_pkg::CNT_W-1:0]          busy_cnt;
    logic                               cke_prev;
    logic                               cke_s1, cke_s2, cke_s3;
    logic                               cke_sync;
    logic                               cmd_ok, fall, rise, held_low, in_pd;
    logic                               chop, ap_pend, ap_done;
    logic [scd_pkg::BANK_W-1:0]         ap_bank, bank_m;
    logic [scd_pkg::NBANK-1:0]          ap_mask;
    logic [scd_pkg::ADDR_W-1:0]         row_mask, col_mask;
    logic [scd_pkg::BANK_W-1:0]         bank_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Clock-enable history and self refresh exit synchroniser
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cke_prev <= 1'b0;
        else
            cke_prev <= cke_i;
    end

    // Exit path must not trust clock edges during self refresh, so resync
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cke_s1 <= 1'b0;
            cke_s2 <= 1'b0;
            cke_s3   <= 1'b0;
            cke_sync <= 1'b0;
        end
        else
        begin
            cke_s1 <= cke_i;
            cke_s2 <= cke_s1;
            cke_s3 <= cke_s2;
            // Agreed level; entry must be seen low before a rise can end it
            if (cke_s2 == cke_s3)
                cke_sync <= cke_s3;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Density masks, one bit each
    genvar gi;
    generate
        for (gi = 0; gi < scd_pkg::ADDR_W; gi++)
        begin : g_mask
            assign row_mask[gi] = (gi < row_bits_i);
            assign col_mask[gi] = (gi < col_bits_i);
        end
        for (gi = 0; gi < scd_pkg::BANK_W; gi++)
        begin : g_bmask
            assign bank_mask[gi] = (gi < bank_bits_i);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Command decode; odt_i plays no part here
    assign in_pd    = (state == scd_pkg::ST_ACT_PD) || (state == scd_pkg::ST_PRE_PD);
    assign held_low = !cke_prev && !cke_i;
    assign fall     = cke_prev && !cke_i;
    assign rise     = !cke_prev && cke_i;
    assign cmd_ok   = cke_prev && cke_i && !in_pd && (state != scd_pkg::ST_SELF_REF);
    assign bank_m   = ba_i & bank_mask;
    assign chop     = otf_bl_i ? !addr_i[scd_pkg::CHOP_BIT] : fixed_bc4_i;

    always_comb
    begin
        if (cs_n_i)
            cmd = scd_pkg::CMD_NOP;
        else
            unique case ({ras_n_i, cas_n_i, we_n_i})
                3'h0: cmd = scd_pkg::CMD_MODE_SET;
                3'h1: cmd = scd_pkg::CMD_REFRESH;
                3'h2: cmd = scd_pkg::CMD_PRECHARGE;
                3'h3: cmd = scd_pkg::CMD_ACTIVATE;
                3'h4: cmd = scd_pkg::CMD_WRITE;
                3'h5: cmd = scd_pkg::CMD_READ;
                3'h6: cmd = scd_pkg::CMD_CALIBRATE;
                3'h7: cmd = scd_pkg::CMD_NOP;
            endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered command outputs; no-ops are not announced
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cmd_strobe_o <= 1'b0;
            cmd_o        <= scd_pkg::CMD_NOP;
            bank_o       <= '0;
            row_o        <= '0;
            col_o        <= '0;
            auto_pre_o   <= 1'b0;
            chop_o       <= 1'b0;
            long_cal_o   <= 1'b0;
        end
        else
        begin
            cmd_strobe_o <= cmd_ok && (cmd != scd_pkg::CMD_NOP);
            if (cmd_ok && (cmd != scd_pkg::CMD_NOP))
            begin
                cmd_o      <= cmd;
                bank_o     <= bank_m;
                row_o      <= addr_i & row_mask;
                col_o      <= addr_i & col_mask;
                auto_pre_o <= addr_i[scd_pkg::AP_BIT];
                chop_o     <= chop;
                long_cal_o <= addr_i[scd_pkg::AP_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending auto precharge, closed when the burst count expires
    assign ap_done = ap_pend && (busy_cnt == scd_pkg::CYC_ONE);
    assign ap_mask = ap_pend ? (scd_pkg::NBANK'(1) << ap_bank) : '0;

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ap_pend <= 1'b0;
            ap_bank <= '0;
        end
        else if (cmd_ok && (cmd == scd_pkg::CMD_READ || cmd == scd_pkg::CMD_WRITE))
        begin
            ap_pend <= addr_i[scd_pkg::AP_BIT];
            ap_bank <= bank_m;
        end
        else if (ap_done)
            ap_pend <= 1'b0;
    end

    scd_bank_table u_banks
    (
        .sys_clk_i   (sys_clk_i),
        .rstn_i      (rstn_i),
        .open_i      (cmd_ok && cmd == scd_pkg::CMD_ACTIVATE),
        .close_i     ((cmd_ok && cmd == scd_pkg::CMD_PRECHARGE) || ap_done),
        .close_all_i (cmd_ok && cmd == scd_pkg::CMD_PRECHARGE && addr_i[scd_pkg::AP_BIT]),
        .bank_i      (ap_done ? ap_bank : bank_m),
        .open_mask_o (open_banks_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State and busy timer; the timer runs on through power-down so bursts end
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state    <= scd_pkg::ST_IDLE;
            busy_cnt <= scd_pkg::CYC_ZERO;
        end
        else
        begin
            if (busy_cnt != scd_pkg::CYC_ZERO)
                busy_cnt <= busy_cnt - scd_pkg::CYC_ONE;
            unique case (state)
                scd_pkg::ST_SELF_REF:
                    if (cke_s2 && cke_s3 && !cke_sync)
                    begin
                        state    <= scd_pkg::ST_IDLE;
                        busy_cnt <= scd_pkg::CYC_XS;
                    end
                scd_pkg::ST_ACT_PD, scd_pkg::ST_PRE_PD:
                    if (rise)
                    begin
                        state    <= (state == scd_pkg::ST_ACT_PD) ? scd_pkg::ST_ACTIVE
                                                                  : scd_pkg::ST_IDLE;
                        busy_cnt <= scd_pkg::CYC_XP;
                    end
                default:
                    if (fall)
                    begin
                        if (state == scd_pkg::ST_IDLE && !cs_n_i &&
                            cmd == scd_pkg::CMD_REFRESH)
                            state <= scd_pkg::ST_SELF_REF;
                        else if (state == scd_pkg::ST_ACTIVE)
                            state <= scd_pkg::ST_ACT_PD;
                        else if (state == scd_pkg::ST_IDLE ||
                                 state == scd_pkg::ST_REFRESHING)
                            state <= scd_pkg::ST_PRE_PD;
                        else if ((open_banks_o & ~ap_mask) == '0)
                            state <= scd_pkg::ST_PRE_PD;
                        else
                            state <= scd_pkg::ST_ACT_PD;
                    end
                    else if (cmd_ok && cmd != scd_pkg::CMD_NOP)
                    begin
                        unique case (cmd)
                            scd_pkg::CMD_MODE_SET:
                                busy_cnt <= scd_pkg::CYC_MRD;
                            scd_pkg::CMD_REFRESH:
                            begin
                                state    <= scd_pkg::ST_REFRESHING;
                                busy_cnt <= scd_pkg::CYC_RFC;
                            end
                            scd_pkg::CMD_PRECHARGE:
                            begin
                                state    <= scd_pkg::ST_PRECHARGING;
                                busy_cnt <= scd_pkg::CYC_RP;
                            end
                            scd_pkg::CMD_ACTIVATE:
                                state <= scd_pkg::ST_ACTIVE;
                            scd_pkg::CMD_WRITE, scd_pkg::CMD_READ:
                            begin
                                state    <= (cmd == scd_pkg::CMD_READ) ? scd_pkg::ST_READING
                                                                       : scd_pkg::ST_WRITING;
                                busy_cnt <= chop ? scd_pkg::CYC_BC4 : scd_pkg::CYC_BL8;
                            end
                            scd_pkg::CMD_CALIBRATE:
                                busy_cnt <= addr_i[scd_pkg::AP_BIT] ? scd_pkg::CYC_ZQCL
                                                                    : scd_pkg::CYC_ZQCS;
                            default:
                                busy_cnt <= busy_cnt;
                        endcase
                    end
                    else if (busy_cnt == scd_pkg::CYC_ONE &&
                             (state == scd_pkg::ST_READING || state == scd_pkg::ST_WRITING ||
                              state == scd_pkg::ST_PRECHARGING ||
                              state == scd_pkg::ST_REFRESHING))
                        state <= ((open_banks_o & ~ap_mask) == '0) ? scd_pkg::ST_IDLE
                                                                   : scd_pkg::ST_ACTIVE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status outputs
    assign state_o          = state;
    assign burst_active_o   = (busy_cnt != scd_pkg::CYC_ZERO) &&
                              (state == scd_pkg::ST_READING || state == scd_pkg::ST_WRITING);
    assign idle_o           = (state == scd_pkg::ST_IDLE) && (open_banks_o == '0) && cke_i &&
                              (busy_cnt == scd_pkg::CYC_ZERO);
    assign own_refresh_en_o = (state == scd_pkg::ST_SELF_REF);
    assign odt_enable_o     = odt_i && (state != scd_pkg::ST_SELF_REF);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    a_deselect_quiet: assert property (cs_n_i |=> !cmd_strobe_o)
        else $error("deselect produced a command");
    a_pd_ignores_cmd: assert property ((in_pd && held_low) |=> !cmd_strobe_o)
        else $error("command taken in power-down");
    a_sr_entry_idle: assert property ((state == scd_pkg::ST_IDLE && fall && !cs_n_i &&
        {ras_n_i, cas_n_i, we_n_i} == 3'h1) |=> state == scd_pkg::ST_SELF_REF)
        else $error("self refresh entry missed");
    a_sr_not_burst: assert property ((state == scd_pkg::ST_READING ||
        state == scd_pkg::ST_WRITING) |=> state != scd_pkg::ST_SELF_REF)
        else $error("self refresh entered from burst");
    a_active_pd: assert property ((state == scd_pkg::ST_ACTIVE && fall)
        |=> state == scd_pkg::ST_ACT_PD)
        else $error("active power-down not entered");
    a_refresh_pd: assert property ((state == scd_pkg::ST_REFRESHING && fall)
        |=> state == scd_pkg::ST_PRE_PD)
        else $error("precharge power-down not entered");
    a_sr_no_odt: assert property (state == scd_pkg::ST_SELF_REF |-> !odt_enable_o)
        else $error("termination enabled in self refresh");
    a_pd_no_refresh: assert property (in_pd |-> !own_refresh_en_o)
        else $error("refresh in power-down");
    a_burst_full: assert property ((cmd_ok && !cs_n_i && {ras_n_i, cas_n_i} == 2'h2 &&
        !chop) |=> burst_active_o [*4] ##1 !burst_active_o)
        else $error("burst length wrong");
    a_sr_exit: assert property ((state == scd_pkg::ST_SELF_REF && cke_s2 && cke_s3 && !cke_sync)
        |=> state == scd_pkg::ST_IDLE && !idle_o)
        else $error("self refresh exit wrong");
    a_idle_means: assert property (idle_o |-> open_banks_o == '0 && !burst_active_o)
        else $error("idle with work pending");

    c_self_ref: cover property (state == scd_pkg::ST_IDLE ##1 state == scd_pkg::ST_SELF_REF);
    c_act_pd:   cover property (state == scd_pkg::ST_ACTIVE ##1 state == scd_pkg::ST_ACT_PD);
    c_read:     cover property (state == scd_pkg::ST_READING ##1 burst_active_o);
    c_mode_set: cover property (cmd_strobe_o && cmd_o == scd_pkg::CMD_MODE_SET);

endmodule // scd_decode

// file: scd_ctrl_model.sv
`timescale 1ns/100ps

// Controller side: owns the command and clock-enable pins of the device
module scd_ctrl_model
(
    // Clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       rstn_i,
    // Requests from the bench
    input  wire logic                       req_i,
    input  wire logic                       cke_req_i,
    input  wire logic [2:0]                 cmd_i,
    input  wire logic [scd_pkg::BANK_W-1:0] ba_req_i,
    input  wire logic [scd_pkg::ADDR_W-1:0] addr_req_i,
    // Pins toward the device
    output logic                            cs_n_o,
    output logic                            ras_n_o,
    output logic                            cas_n_o,
    output logic                            we_n_o,
    output logic                            cke_o,
    output logic [scd_pkg::BANK_W-1:0]      ba_o,
    output logic [scd_pkg::ADDR_W-1:0]      addr_o
);
    logic [20:0] pins;

    assign {cs_n_o, ras_n_o, cas_n_o, we_n_o, ba_o, addr_o} = pins;

    // Pins move just after an edge; spacing is kept by the bench
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pins  <= 21'h100000;
            cke_o <= 1'b0;
        end
        else
        begin
            cke_o <= cke_req_i;
            if (req_i)
                pins <= {1'b0, cmd_i, ba_req_i, addr_req_i};
            else if (!cke_req_i && !cke_o)
                pins <= ~pins;                 // Lines float while held low
            else
                pins <= {1'b1, ~pins[19:0]};   // Deselect at every transition that carries no request, unless clock-enable is held low
        end
    end
endmodule // scd_ctrl_model

// file: scd_decode_tb.sv
`timescale 1ns/100ps

module scd_decode_tb;
    logic                 sys_clk_i = 1'b0;
    logic                 rstn_i    = 1'b0;
    logic                 req       = 1'b0;
    logic                 cke_req   = 1'b0;
    logic                 odt       = 1'b0;
    scd_pkg::scd_cmd_type cmd       = scd_pkg::CMD_NOP;
    logic [2:0]           ba_req    = 3'h0;
    logic [13:0]          addr_req  = 14'h0000;
    logic                 cs_n, ras_n, cas_n, we_n, cke, strobe, ap, chop, burst, idle, own, odt_en;
    logic                 lcal;
    logic [2:0]           ba, bank;
    logic [13:0]          addr, col, row;
    logic [7:0]           open_b;
    scd_pkg::scd_cmd_type cmd_out;
    scd_pkg::scd_state_type state;
    int                   fail_count = 0;
    int                   checks_done = 0;
    int                   seed = 64;
    int                   cnt;
    logic [36:0]          exp_q[$];
    scd_pkg::scd_cmd_type seq[7] = '{scd_pkg::CMD_ACTIVATE, scd_pkg::CMD_WRITE, scd_pkg::CMD_READ,
        scd_pkg::CMD_MODE_SET, scd_pkg::CMD_CALIBRATE, scd_pkg::CMD_PRECHARGE, scd_pkg::CMD_REFRESH};

    scd_ctrl_model scd_ctrl_model_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_i(req),
        .cke_req_i(cke_req), .cmd_i(cmd), .ba_req_i(ba_req), .addr_req_i(addr_req), .cs_n_o(cs_n),
        .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .cke_o(cke), .ba_o(ba), .addr_o(addr));

    scd_decode scd_decode_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n),
        .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .cke_i(cke), .odt_i(odt), .ba_i(ba),
        .addr_i(addr), .otf_bl_i(1'b1), .fixed_bc4_i(1'b0), .row_bits_i(4'hd),
        .col_bits_i(4'ha), .bank_bits_i(2'h3), .cmd_strobe_o(strobe), .cmd_o(cmd_out),
        .bank_o(bank), .row_o(row), .col_o(col), .auto_pre_o(ap), .chop_o(chop),
        .long_cal_o(lcal),
        .state_o(state), .open_banks_o(open_b), .burst_active_o(burst), .idle_o(idle),
        .own_refresh_en_o(own), .odt_enable_o(odt_en));

    // 250 MHz clock
    always #2 sys_clk_i = ~sys_clk_i;

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One command with random bank; expectation noted as it is sent
    task issue(input scd_pkg::scd_cmd_type c, input logic [13:0] a);
        logic [2:0] b;
        logic       rw;
        b = 3'($random(seed));
        rw = (c == scd_pkg::CMD_WRITE) || (c == scd_pkg::CMD_READ);
        @(posedge sys_clk_i);
        req <= 1'b1;
        cmd <= c;
        ba_req <= b;
        addr_req <= a;
        exp_q.push_back({c, b, a & 14'h1fff, a & 14'h03ff, rw ? {a[10], ~a[12]} : 2'b00,
            (c == scd_pkg::CMD_CALIBRATE) & a[10]});
        @(posedge sys_clk_i);
        req <= 1'b0;
    endtask

    // Let n edges pass, then sample where outputs have settled
    task wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask

    // Oldest note against every strobe; an unexpected strobe is a mismatch
    always @(negedge sys_clk_i)
    begin
        if (strobe === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(32'h1, 32'h0);
            else
                check({cmd_out, bank, row, col, ((cmd_out == scd_pkg::CMD_WRITE) ||
                    (cmd_out == scd_pkg::CMD_READ)) ? {ap, chop} : 2'b00,
                    (cmd_out == scd_pkg::CMD_CALIBRATE) & lcal},
                    exp_q.pop_front());
        end
    end

    // Watchdog sized well above the expected run
    initial
    begin
        #12000;
        fail_count++;
        test_done;
    end

    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        rstn_i <= 1'b1; // Held high from here on
        cke_req <= 1'b1;
        wait_cyc(4);
        // Every strobe code, precharge forced to all banks
        // Each busy period runs out before the next command, as the controller must
        foreach (seq[i])
        begin
            issue(seq[i], 14'($random(seed)) |
                ((seq[i] == scd_pkg::CMD_PRECHARGE) ? 14'h0400 : 14'h0000));
            wait_cyc(140);
        end
        wait_cyc(100);
        check({idle, state, open_b}, {1'b1, scd_pkg::ST_IDLE, 8'h00});
        // Self refresh entry from idle with termination requested
        @(posedge sys_clk_i);
        req <= 1'b1;
        cmd <= scd_pkg::CMD_REFRESH;
        cke_req <= 1'b0;
        odt <= 1'b1;
        @(posedge sys_clk_i);
        req <= 1'b0;
        wait_cyc(6);
        check({state, own, odt_en}, {scd_pkg::ST_SELF_REF, 2'b10});
        cke_req <= 1'b1;
        wait_cyc(7);
        check({state, idle, odt_en}, {scd_pkg::ST_IDLE, 2'b01});
        wait_cyc(90);
        // Precharge power-down from idle, no own refresh; no writes follow exit
        cke_req <= 1'b0;
        wait_cyc(4);
        check({state, own}, {scd_pkg::ST_PRE_PD, 1'b0});
        cke_req <= 1'b1;
        wait_cyc(4);
        check(state, scd_pkg::ST_IDLE);
        // Bursts of both lengths run their full count
        issue(scd_pkg::CMD_ACTIVATE, 14'($random(seed)));
        for (int k = 0; k < 2; k++)
        begin
            issue(scd_pkg::CMD_READ, k[0] ? 14'h1000 : 14'h0000);
            cnt = 0;
            repeat (12)
            begin
                @(negedge sys_clk_i);
                cnt += (burst === 1'b1);
            end
            check(cnt, k ? scd_pkg::CYC_BL8 : scd_pkg::CYC_BC4);
        end
        // Active power-down with floating lines
        cke_req <= 1'b0;
        wait_cyc(10);
        check({state, own}, {scd_pkg::ST_ACT_PD, 1'b0});
        cke_req <= 1'b1;
        wait_cyc(4);
        check(state, scd_pkg::ST_ACTIVE);
        check(exp_q.size(), 0);
        test_done;
    end
endmodule // scd_decode_tb
